// file: hdl/smv_defs.svh
// Summary of operation
// - Controller sends one request per message
// - One request per enable rising edge
// - Service 4C writes, 4B reads setup
// - Class 4, attribute zero on every request
// - Instance 201 channel one, 202 two
// - Write payload exactly 28 bytes
// - Read request carries zero-length payload
// - Read returns into destination array
// - Channel two write in single mode: code 10
// - Reserved config bits or mode: code 1
// - Gradient outside 80000..99999: code 2
// - Length outside unit range: code 3
// - Count outside 2..limit: code 4
// - Extended code valid only when general 9
// - Error held until valid write accepted
// - Invalid block discarded, nothing stored
// - Payload is seven 32-bit setup words
// - Read returns seven words plus offset
`ifndef SMV_DEFS_SVH
`define SMV_DEFS_SVH
`define SMV_SVC_WRITE     8'h4c
`define SMV_SVC_READ      8'h4b
`define SMV_CLASS         8'h04
`define SMV_ATTR          8'h00
`define SMV_INST_CH1      8'hc9
`define SMV_INST_CH2      8'hca
`define SMV_WR_BYTES      8'h1c
`define SMV_RD_BYTES      8'h00
`define SMV_WR_WORDS      3'h7
`define SMV_RD_WORDS      4'h8
`define SMV_GEN_OK        8'h00
`define SMV_GEN_ERR       8'h09
`define SMV_GEN_BADREQ    8'h08
`define SMV_EXT_NONE      32'h0000_0000
`define SMV_EXT_CFG       32'h0000_0001
`define SMV_EXT_GRAD      32'h0000_0002
`define SMV_EXT_LEN       32'h0000_0003
`define SMV_EXT_CNT       32'h0000_0004
`define SMV_EXT_CHAN      32'h0000_000a
`define SMV_CFG_RSV_MASK  32'hfffe_00ff
`define SMV_CFG_MM_BIT    13
`define SMV_CFG_MODE_MSB  16
`define SMV_GRAD_MIN      32'h0001_3880
`define SMV_GRAD_MAX      32'h0001_869f
`define SMV_LEN_IN_MIN    32'h0000_0002
`define SMV_LEN_IN_MAX    32'h0000_0320
`define SMV_LEN_MM_MIN    32'h0000_0032
`define SMV_LEN_MM_MAX    32'h0000_4f60
`define SMV_CNT_MIN       32'h0000_0002
`define SMV_CNT_IN_MUL    32'h0000_03e8
`define SMV_CNT_MM_MUL    32'h0000_000a
`define SMV_DEF_GRAD      32'h0001_5f90
`define SMV_DEF_LEN       32'h0000_0010
`define SMV_DEF_CNT       32'h0000_3e80
`endif

// file: hdl/smv_pkg.sv
package smv_pkg;
    typedef logic [31:0] smv_word_t;
    typedef enum logic [1:0] {SMV_CH1, SMV_CH2, SMV_CH_BAD} smv_chan_t;
endpackage : smv_pkg

// file: hdl/smv_if.sv
`timescale 1ns/1ns
// Message link between controller end and device end
interface smv_if;
    // Request
    logic        req_valid;
    logic [7:0]  req_service;
    logic [7:0]  req_class;
    logic [7:0]  req_instance;
    logic [7:0]  req_attribute;
    logic [7:0]  req_length;
    logic        req_data_valid;
    logic [31:0] req_data;
    // Response
    logic        rsp_valid;
    logic [7:0]  rsp_gen_err;
    logic [31:0] rsp_ext_err;
    logic        rsp_data_valid;
    logic [31:0] rsp_data;
    logic        rsp_done;

    modport ctrl (
        output req_valid, req_service, req_class, req_instance,
               req_attribute, req_length, req_data_valid, req_data,
        input  rsp_valid, rsp_gen_err, rsp_ext_err, rsp_data_valid,
               rsp_data, rsp_done
    );
    modport dev (
        input  req_valid, req_service, req_class, req_instance,
               req_attribute, req_length, req_data_valid, req_data,
        output rsp_valid, rsp_gen_err, rsp_ext_err, rsp_data_valid,
               rsp_data, rsp_done
    );
endinterface : smv_if

// file: hdl/smv_device.sv
`timescale 1ns/1ns
`include "smv_defs.svh"
// ==========================================
// Device end: setup message validator
module smv_device (
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    // Message link
    smv_if.dev                    link,
    // Rack configuration
    input  wire logic             dual_chan_i,
    // Apply-preset offsets per channel
    input  wire smv_pkg::smv_word_t offset_ch1_i,
    input  wire smv_pkg::smv_word_t offset_ch2_i,
    input  wire logic             offset_clr_ack_i,
    // Stored setup and status
    output logic                  setup_upd_ch1_o,
    output logic                  setup_upd_ch2_o,
    output logic                  msg_err_o,
    output smv_pkg::smv_word_t    ext_err_o
);
    import smv_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_COLLECT, S_CHECK, S_RESP,
                              S_READ, S_DONE} smv_dev_st_t;

    smv_dev_st_t st_q;
    smv_chan_t   chan_q;
    logic        bad_req_q;
    logic [2:0]  widx_q;
    logic [3:0]  ridx_q;
    smv_word_t   buf_q [0:6];
    smv_word_t   store_q [0:1][0:6];
    smv_word_t   code_d;

    // ==========================================
    // Request header decode
    smv_chan_t   chan_d;
    logic        hdr_ok;
    always_comb
    begin
        chan_d = SMV_CH_BAD;
        if (link.req_instance == `SMV_INST_CH1)
            chan_d = SMV_CH1;
        else if (link.req_instance == `SMV_INST_CH2)
            chan_d = SMV_CH2;
        hdr_ok = (link.req_class == `SMV_CLASS) &&
                 (link.req_attribute == `SMV_ATTR) &&
                 (chan_d != SMV_CH_BAD) &&
                 (((link.req_service == `SMV_SVC_WRITE) &&
                   (link.req_length == `SMV_WR_BYTES)) ||
                  ((link.req_service == `SMV_SVC_READ) &&
                   (link.req_length == `SMV_RD_BYTES)));
    end

    // ==========================================
    // Payload checks, channel code 10 first, then lowest code wins
    logic        mm;
    logic [2:0]  mode;
    logic [41:0] cnt_lim;
    always_comb
    begin
        mm      = buf_q[0][`SMV_CFG_MM_BIT];
        mode    = buf_q[0][`SMV_CFG_MODE_MSB -: 3];
        cnt_lim = {10'h0, buf_q[2]} *
                  (mm ? {10'h0, `SMV_CNT_MM_MUL} : {10'h0, `SMV_CNT_IN_MUL});
        code_d  = `SMV_EXT_NONE;
        if (chan_q == SMV_CH2 && !dual_chan_i)
            code_d = `SMV_EXT_CHAN;
        else if (((buf_q[0] & `SMV_CFG_RSV_MASK) != 32'h0) ||
                 mode[2])
            code_d = `SMV_EXT_CFG;
        else if (buf_q[1] < `SMV_GRAD_MIN ||
                 buf_q[1] > `SMV_GRAD_MAX)
            code_d = `SMV_EXT_GRAD;
        else if (mm ? (buf_q[2] < `SMV_LEN_MM_MIN ||
                       buf_q[2] > `SMV_LEN_MM_MAX)
                    : (buf_q[2] < `SMV_LEN_IN_MIN ||
                       buf_q[2] > `SMV_LEN_IN_MAX))
            code_d = `SMV_EXT_LEN;
        else if (buf_q[3] < `SMV_CNT_MIN ||
                 {10'h0, buf_q[3]} > cnt_lim)
            code_d = `SMV_EXT_CNT;
    end

    // ==========================================
    // Message sequencer
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            st_q       <= S_IDLE;
            chan_q     <= SMV_CH1;
            bad_req_q  <= 1'b0;
            widx_q     <= 3'h0;
            ridx_q     <= 4'h0;
        end
        else
        begin
            case (st_q)
                S_IDLE:
                begin
                    widx_q <= 3'h0;
                    ridx_q <= 4'h0;
                    if (link.req_valid)
                    begin
                        chan_q     <= chan_d;
                        bad_req_q  <= !hdr_ok;
                        if (hdr_ok &&
                            link.req_service == `SMV_SVC_WRITE)
                            st_q <= S_COLLECT;
                        else if (hdr_ok)
                            st_q <= S_READ;
                        else
                            st_q <= S_RESP;
                    end
                end
                S_COLLECT:
                    if (link.req_data_valid)
                    begin
                        widx_q <= widx_q + 3'h1;
                        if (widx_q == `SMV_WR_WORDS - 3'h1)
                            st_q <= S_CHECK;
                    end
                S_CHECK:
                    st_q <= S_RESP;
                S_READ:
                begin
                    ridx_q <= ridx_q + 4'h1;
                    if (ridx_q == `SMV_RD_WORDS - 4'h1)
                        st_q <= S_RESP;
                end
                S_RESP:
                    st_q <= S_DONE;
                S_DONE:
                    st_q <= S_IDLE;
                default:
                    st_q <= S_IDLE;
            endcase
        end
    end

    // ==========================================
    // Payload capture
    always_ff @(posedge ref_clk_i)
    begin
        if (st_q == S_COLLECT && link.req_data_valid)
            buf_q[widx_q] <= link.req_data;
    end

    // ==========================================
    // Setup store, only whole valid blocks
    logic commit;
    assign commit = st_q == S_CHECK && code_d == `SMV_EXT_NONE;
    generate
        for (genvar c = 0; c < 2; c++)
        begin : g_chan
            for (genvar w = 0; w < `SMV_WR_WORDS; w++)
            begin : g_word
                always_ff @(posedge ref_clk_i)
                begin
                    if (!rst_n_i)
                        store_q[c][w] <= (w == 1) ? `SMV_DEF_GRAD :
                                         (w == 2) ? `SMV_DEF_LEN :
                                         (w == 3) ? `SMV_DEF_CNT :
                                         32'h0;
                    else if (commit && chan_q == smv_chan_t'(c))
                        store_q[c][w] <= buf_q[w];
                end
            end
        end
    endgenerate

    // ==========================================
    // Sticky error and update strobes
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            msg_err_o       <= 1'b0;
            ext_err_o       <= `SMV_EXT_NONE;
            setup_upd_ch1_o <= 1'b0;
            setup_upd_ch2_o <= 1'b0;
        end
        else
        begin
            setup_upd_ch1_o <= commit && chan_q == SMV_CH1;
            setup_upd_ch2_o <= commit && chan_q == SMV_CH2;
            if (st_q == S_CHECK)
            begin
                msg_err_o <= code_d != `SMV_EXT_NONE;
                ext_err_o <= code_d;
            end
        end
    end

    // ==========================================
    // Response outputs
    smv_word_t rd_word;
    always_comb
    begin
        if (ridx_q == `SMV_RD_WORDS - 4'h1)
            rd_word = (chan_q == SMV_CH2) ? offset_ch2_i
                                          : offset_ch1_i;
        else
            rd_word = store_q[chan_q == SMV_CH2][ridx_q[2:0]];
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            link.rsp_valid      <= 1'b0;
            link.rsp_gen_err    <= `SMV_GEN_OK;
            link.rsp_ext_err    <= `SMV_EXT_NONE;
            link.rsp_data_valid <= 1'b0;
            link.rsp_data       <= 32'h0;
            link.rsp_done       <= 1'b0;
        end
        else
        begin
            link.rsp_data_valid <= st_q == S_READ;
            link.rsp_data       <= (st_q == S_READ) ? rd_word : 32'h0;
            link.rsp_valid      <= st_q == S_RESP;
            link.rsp_done       <= st_q == S_DONE;
            if (st_q == S_RESP)
            begin
                if (bad_req_q)
                begin
                    link.rsp_gen_err <= `SMV_GEN_BADREQ;
                    link.rsp_ext_err <= `SMV_EXT_NONE;
                end
                else
                begin
                    link.rsp_gen_err <= msg_err_o ? `SMV_GEN_ERR
                                                  : `SMV_GEN_OK;
                    link.rsp_ext_err <= ext_err_o;
                end
            end
        end
    end
endmodule : smv_device

// file: hdl/smv_ctrl.sv
`timescale 1ns/1ns
`include "smv_defs.svh"
// ==========================================
// Controller end: issues setup messages
module smv_ctrl (
    // Clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               rst_n_i,
    // Message link
    smv_if.ctrl                     link,
    // User request
    input  wire logic               enable_i,
    input  wire logic               write_i,
    input  wire logic               chan2_i,
    input  wire smv_pkg::smv_word_t wdata_i [0:6],
    // User results
    output logic                    busy_o,
    output logic                    done_o,
    output logic                    err_o,
    output smv_pkg::smv_word_t      ext_err_o,
    output smv_pkg::smv_word_t      rdata_o [0:7]
);
    import smv_pkg::*;

    typedef enum logic [1:0] {C_IDLE, C_SEND, C_WAIT} smv_ctrl_st_t;

    smv_ctrl_st_t st_q;
    logic         en_q;
    logic [2:0]   widx_q;
    logic [3:0]   ridx_q;

    // ==========================================
    // Edge of enabling condition
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            en_q <= 1'b0;
        else
            en_q <= enable_i;
    end

    // ==========================================
    // Request sequencer
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            st_q                <= C_IDLE;
            widx_q              <= 3'h0;
            ridx_q              <= 4'h0;
            busy_o              <= 1'b0;
            done_o              <= 1'b0;
            err_o               <= 1'b0;
            ext_err_o           <= `SMV_EXT_NONE;
            link.req_valid      <= 1'b0;
            link.req_service    <= `SMV_SVC_READ;
            link.req_class      <= `SMV_CLASS;
            link.req_instance   <= `SMV_INST_CH1;
            link.req_attribute  <= `SMV_ATTR;
            link.req_length     <= `SMV_RD_BYTES;
            link.req_data_valid <= 1'b0;
            link.req_data       <= 32'h0;
        end
        else
        begin
            done_o              <= 1'b0;
            link.req_valid      <= 1'b0;
            link.req_data_valid <= 1'b0;
            case (st_q)
                C_IDLE:
                    if (enable_i && !en_q)
                    begin
                        busy_o            <= 1'b1;
                        widx_q            <= 3'h0;
                        ridx_q            <= 4'h0;
                        link.req_valid    <= 1'b1;
                        link.req_class    <= `SMV_CLASS;
                        link.req_attribute <= `SMV_ATTR;
                        link.req_instance <= chan2_i ? `SMV_INST_CH2
                                           : `SMV_INST_CH1;
                        link.req_service  <= write_i ? `SMV_SVC_WRITE
                                                     : `SMV_SVC_READ;
                        link.req_length   <= write_i ? `SMV_WR_BYTES
                                           : `SMV_RD_BYTES;
                        st_q <= write_i ? C_SEND : C_WAIT;
                    end
                C_SEND:
                begin
                    link.req_data_valid <= 1'b1;
                    link.req_data       <= wdata_i[widx_q];
                    widx_q              <= widx_q + 3'h1;
                    if (widx_q == `SMV_WR_WORDS - 3'h1)
                        st_q <= C_WAIT;
                end
                C_WAIT:
                begin
                    if (link.rsp_data_valid)
                        ridx_q <= ridx_q + 4'h1;
                    if (link.rsp_valid)
                    begin
                        err_o     <= link.rsp_gen_err != `SMV_GEN_OK;
                        ext_err_o <= (link.rsp_gen_err == `SMV_GEN_ERR)
                                     ? link.rsp_ext_err
                                     : `SMV_EXT_NONE;
                    end
                    if (link.rsp_done)
                    begin
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        st_q   <= C_IDLE;
                    end
                end
                default:
                    st_q <= C_IDLE;
            endcase
        end
    end

    // ==========================================
    // Read destination array
    generate
        for (genvar i = 0; i < `SMV_RD_WORDS; i++)
        begin : g_rd
            always_ff @(posedge ref_clk_i)
            begin
                if (!rst_n_i)
                    rdata_o[i] <= 32'h0;
                else if (st_q == C_WAIT && link.rsp_data_valid &&
                         ridx_q == 4'(i))
                    rdata_o[i] <= link.rsp_data;
            end
        end
    endgenerate
endmodule : smv_ctrl

// file: test/smv_properties.sv
`timescale 1ns/1ns
`include "smv_defs.svh"
// ==========================================
// Link checker between controller and device
module smv_properties (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    // Request side
    input wire logic        req_valid,
    input wire logic [7:0]  req_service,
    input wire logic [7:0]  req_class,
    input wire logic [7:0]  req_instance,
    input wire logic [7:0]  req_attribute,
    input wire logic [7:0]  req_length,
    input wire logic        req_data_valid,
    // Response side
    input wire logic        rsp_valid,
    input wire logic [7:0]  rsp_gen_err,
    input wire logic [31:0] rsp_ext_err,
    input wire logic        rsp_data_valid,
    input wire logic        rsp_done
);
    import smv_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Message steps
    sequence wr_hdr_s;
        req_valid && req_service == `SMV_SVC_WRITE;
    endsequence
    sequence rd_hdr_s;
        req_valid && req_service == `SMV_SVC_READ;
    endsequence
    sequence wr_words_s;
        req_data_valid [*7] ##1 !req_data_valid;
    endsequence
    sequence end_s;
        rsp_valid ##1 rsp_done;
    endsequence
    // Header fields
    hdr_fixed_a: assert property (req_valid |-> req_class == `SMV_CLASS
        && req_attribute == `SMV_ATTR) else $error("bad class or attribute");
    inst_sel_a: assert property (req_valid |-> req_instance inside
        {`SMV_INST_CH1, `SMV_INST_CH2}) else $error("bad instance");
    svc_code_a: assert property (req_valid |-> req_service inside
        {`SMV_SVC_WRITE, `SMV_SVC_READ}) else $error("bad service");
    wr_length_a: assert property (wr_hdr_s |->
        req_length == `SMV_WR_BYTES) else $error("bad write length");
    rd_nodata_a: assert property (rd_hdr_s |->
        req_length == `SMV_RD_BYTES ##1 !req_data_valid [*8])
        else $error("read carries data");
    // Transfer shapes
    wr_words_a: assert property (wr_hdr_s |=> wr_words_s)
        else $error("write not seven words");
    wr_answer_a: assert property (wr_hdr_s |-> ##[9:11] end_s)
        else $error("write answer late");
    rd_answer_a: assert property (rd_hdr_s |-> ##2 rsp_data_valid [*8]
        ##1 end_s) else $error("read answer shape");
    one_msg_a: assert property (req_valid |=> !req_valid [*8])
        else $error("request repeated");
    // Error codes
    ext_gate_a: assert property (rsp_valid &&
        rsp_gen_err != `SMV_GEN_ERR |-> rsp_ext_err == `SMV_EXT_NONE)
        else $error("ext code without 9");
    ext_set_a: assert property (rsp_valid &&
        rsp_gen_err == `SMV_GEN_ERR |-> rsp_ext_err inside {`SMV_EXT_CFG,
        `SMV_EXT_GRAD, `SMV_EXT_LEN, `SMV_EXT_CNT, `SMV_EXT_CHAN})
        else $error("unknown ext code");
endmodule : smv_properties

// file: test/setup_message_validator_tb.sv
`timescale 1ns/1ns
`include "smv_defs.svh"
// ==========================================
// Bench for both link ends
module setup_message_validator_tb;
    import smv_pkg::*;
    logic      ref_clk_i, rst_n_i, enable_i, write_i, chan2_i, dual_chan_i;
    logic      busy_o, done_o, err_o, upd1, upd2, msg_err, upd_b1, upd_b2;
    smv_word_t wdata_i [0:6];
    smv_word_t rdata_o [0:7];
    smv_word_t store   [1:2][0:6];
    smv_word_t off1, off2, c_ext, d_ext, sticky, code;
    int        error_cnt = 0, n_tests = 0, n_req = 0, n_msg = 0;
    int        n_upd1 = 0, n_upd2 = 0, n_bad = 0, u0, ch;
    logic      c2;
    smv_if link_if ();
    smv_if bad_if ();
    // Design ends and checker
    smv_ctrl u_smv_ctrl (.ref_clk_i, .rst_n_i, .link(link_if), .enable_i,
        .write_i, .chan2_i, .wdata_i, .busy_o, .done_o, .err_o,
        .ext_err_o(c_ext), .rdata_o);
    smv_device u_smv_device (.ref_clk_i, .rst_n_i, .link(link_if),
        .dual_chan_i, .offset_ch1_i(off1), .offset_ch2_i(off2),
        .offset_clr_ack_i(1'b0), .setup_upd_ch1_o(upd1),
        .setup_upd_ch2_o(upd2), .msg_err_o(msg_err), .ext_err_o(d_ext));
    smv_device u_smv_device2 (.ref_clk_i, .rst_n_i, .link(bad_if),
        .dual_chan_i(1'b1), .offset_ch1_i(off1), .offset_ch2_i(off2),
        .offset_clr_ack_i(1'b0), .setup_upd_ch1_o(upd_b1),
        .setup_upd_ch2_o(upd_b2), .msg_err_o(), .ext_err_o());
    smv_properties u_props (.ref_clk_i, .rst_n_i,
        .req_valid(link_if.req_valid), .req_service(link_if.req_service),
        .req_class(link_if.req_class), .req_instance(link_if.req_instance),
        .req_attribute(link_if.req_attribute),
        .req_length(link_if.req_length),
        .req_data_valid(link_if.req_data_valid),
        .rsp_valid(link_if.rsp_valid), .rsp_gen_err(link_if.rsp_gen_err),
        .rsp_ext_err(link_if.rsp_ext_err),
        .rsp_data_valid(link_if.rsp_data_valid), .rsp_done(link_if.rsp_done));
    // Clock
    initial
    begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    // Event counters
    always @(posedge ref_clk_i)
    begin
        if (link_if.req_valid === 1'b1) n_req++;
        if (upd1 === 1'b1) n_upd1++;
        if (upd2 === 1'b1) n_upd2++;
        if (upd_b1 === 1'b1 || upd_b2 === 1'b1) n_bad++;
    end
    task automatic chk(input smv_word_t got, input smv_word_t exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Model of the data checks, channel code 10 first, then lowest code
    function automatic smv_word_t exp_code(input smv_word_t w [0:6],
                                           input logic cc, input logic dual);
        logic mm;
        longint lim;
        mm = w[0][`SMV_CFG_MM_BIT];
        lim = longint'(w[2]) * (mm ? `SMV_CNT_MM_MUL : `SMV_CNT_IN_MUL);
        if (cc && !dual) return `SMV_EXT_CHAN;
        if ((w[0] & `SMV_CFG_RSV_MASK) != 32'h0 || w[0][`SMV_CFG_MODE_MSB])
            return `SMV_EXT_CFG;
        if (w[1] < `SMV_GRAD_MIN || w[1] > `SMV_GRAD_MAX) return `SMV_EXT_GRAD;
        if (mm ? (w[2] < `SMV_LEN_MM_MIN || w[2] > `SMV_LEN_MM_MAX)
               : (w[2] < `SMV_LEN_IN_MIN || w[2] > `SMV_LEN_IN_MAX))
            return `SMV_EXT_LEN;
        if (w[3] < `SMV_CNT_MIN || w[3] > lim) return `SMV_EXT_CNT;
        return `SMV_EXT_NONE;
    endfunction : exp_code
    // Boundary-biased value
    function automatic smv_word_t pick(input smv_word_t lo,
                                       input smv_word_t hi);
        case ($urandom % 5)
            0: return lo;
            1: return hi;
            2: return lo - 32'h1;
            3: return hi + 32'h1;
            default: return lo + $urandom % (hi - lo + 32'h1);
        endcase
    endfunction : pick
    // One message, enable held past completion
    task automatic send(input logic wr, input logic cc);
        int k;
        @(negedge ref_clk_i);
        write_i = wr;
        chan2_i = cc;
        enable_i = 1'b1;
        n_msg++;
        k = 0;
        while (done_o !== 1'b1 && k < 40)
        begin
            @(negedge ref_clk_i);
            k++;
            if (k == 1) chk({31'h0, busy_o}, 32'h1);
        end
        chk({31'h0, done_o}, 32'h1);
        chk({31'h0, busy_o}, 32'h0);
        repeat (3) @(negedge ref_clk_i);
        enable_i = 1'b0;
    endtask : send
    task automatic rd_chk(input int c);
        send(1'b0, c == 2);
        for (int j = 0; j < 7; j++) chk(rdata_o[j], store[c][j]);
        chk(rdata_o[7], (c == 2) ? off2 : off1);
        chk(c_ext, sticky);
    endtask : rd_chk
    // Malformed header into the second device
    task automatic bad_msg(input logic [7:0] svc, cls, inst, attr, len);
        @(negedge ref_clk_i);
        bad_if.req_service = svc;
        bad_if.req_class = cls;
        bad_if.req_instance = inst;
        bad_if.req_attribute = attr;
        bad_if.req_length = len;
        bad_if.req_valid = 1'b1;
        @(negedge ref_clk_i);
        bad_if.req_valid = 1'b0;
        for (int k = 0; k < 30 && bad_if.rsp_valid !== 1'b1; k++)
        begin
            bad_if.req_data_valid = (k < 7);
            bad_if.req_data = $urandom;
            @(negedge ref_clk_i);
        end
        bad_if.req_data_valid = 1'b0;
        chk({24'h0, bad_if.rsp_gen_err}, {24'h0, `SMV_GEN_BADREQ});
        chk(bad_if.rsp_ext_err, `SMV_EXT_NONE);
    endtask : bad_msg
    task end_sim;
        $display("errors=%0d tests=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // Watchdog
    initial
    begin
        #(5000 * 50);
        error_cnt++;
        $display("mismatch t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end_sim();
    end
    // Main sequence
    initial
    begin
        {rst_n_i, enable_i, write_i, chan2_i, dual_chan_i} = 5'h01;
        {bad_if.req_valid, bad_if.req_data_valid} = 2'h0;
        bad_if.req_data = 32'h0;
        off1 = 32'h0;
        off2 = 32'h0;
        sticky = 32'h0;
        wdata_i = '{default: 32'h0};
        for (int c = 1; c <= 2; c++)
            store[c] = '{32'h0, `SMV_DEF_GRAD, `SMV_DEF_LEN, `SMV_DEF_CNT,
                         32'h0, 32'h0, 32'h0};
        void'($urandom(26));
        repeat (4) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        rd_chk(1);
        rd_chk(2);
        bad_msg(`SMV_SVC_WRITE, 8'h05, `SMV_INST_CH1, 8'h00, 8'h1c);
        bad_msg(`SMV_SVC_WRITE, 8'h04, `SMV_INST_CH1, 8'h01, 8'h1c);
        bad_msg(`SMV_SVC_WRITE, 8'h04, 8'hcb, 8'h00, 8'h1c);
        bad_msg(`SMV_SVC_WRITE, 8'h04, `SMV_INST_CH2, 8'h00, 8'h00);
        bad_msg(`SMV_SVC_READ, 8'h04, `SMV_INST_CH1, 8'h00, 8'h1c);
        chk(smv_word_t'(n_bad), 32'h0);
        for (int i = 0; i < 30; i++)
        begin
            dual_chan_i = ($urandom % 4 != 0);
            off1 = $urandom;
            off2 = $urandom;
            c2 = 1'($urandom % 2);
            wdata_i[0] = ($urandom & 32'h0000_ff00)
                       | (($urandom % 4 == 0) ? 32'h1 << ($urandom % 32) : 0);
            if (i == 1) wdata_i[0][`SMV_CFG_MODE_MSB] = 1'b1;
            wdata_i[1] = pick(`SMV_GRAD_MIN, `SMV_GRAD_MAX);
            wdata_i[2] = wdata_i[0][`SMV_CFG_MM_BIT]
                       ? pick(`SMV_LEN_MM_MIN, `SMV_LEN_MM_MAX)
                       : pick(`SMV_LEN_IN_MIN, `SMV_LEN_IN_MAX);
            wdata_i[3] = pick(`SMV_CNT_MIN, wdata_i[2] *
                (wdata_i[0][`SMV_CFG_MM_BIT] ? `SMV_CNT_MM_MUL
                                             : `SMV_CNT_IN_MUL));
            for (int j = 4; j < 7; j++) wdata_i[j] = $urandom;
            code = exp_code(wdata_i, c2, dual_chan_i);
            u0 = n_upd1 + 2 * n_upd2;
            send(1'b1, c2);
            sticky = code;
            if (code == `SMV_EXT_NONE) store[c2 + 1] = wdata_i;
            chk(c_ext, sticky);
            chk({31'h0, err_o}, {31'h0, sticky != 0});
            chk(d_ext, sticky);
            chk({31'h0, msg_err}, {31'h0, sticky != 0});
            chk(smv_word_t'(n_upd1 + 2 * n_upd2 - u0),
                (code == 0) ? (c2 ? 32'h2 : 32'h1) : 32'h0);
            ch = dual_chan_i ? 1 + $urandom % 2 : 1;
            rd_chk(ch);
        end
        chk(smv_word_t'(n_req), smv_word_t'(n_msg));
        end_sim();
    end
endmodule : setup_message_validator_tb
